// File: design/background_debug_pin_link.sv
`timescale 1ns/1ns
interface debug_pin_link;
  logic tgtOut;
  logic tgtOe;
  logic hostOut;
  logic hostOe;
  logic pinLevel;
  // open-drain style wire with pull-up: any driven low wins
  assign pinLevel = !((tgtOe && !tgtOut) || (hostOe && !hostOut));
  modport target (input pinLevel, output tgtOut, output tgtOe);
  modport host (input pinLevel, output hostOut, output hostOe);
endinterface

// File: design/debug_ack_host.sv
`timescale 1ns/1ns
`include "debug_ack_params.svh"
module debug_ack_host
  import debug_ack_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  debug_pin_link.host link,
  input  wire logic cmdSent,
  input  wire logic abortReq,
  input  wire logic statusClear,
  output logic      ackSeen,
  output logic      ackWaiting,
  output logic      syncDone,
  output logic      statusCheck
);
  host_state_type  state_r;
  host_state_type  state_nxt;
  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] cnt_nxt;
  logic            pin1_r;
  logic            pin2_r;
  logic            pinOut_r;
  logic            pinOe_r;

  wire cnt0   = cnt_r == `CNT_W'(0);
  // sync stage lags its own release
  wire settle = cnt0;
  // marker above the settle range: response low seen
  wire respLow = cnt_r == `CNT_W'(`PIN_SYNC_LAT + 1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      {pin1_r, pin2_r} <= 2'h3;
    else
      {pin1_r, pin2_r} <= {link.pinLevel, pin1_r};
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt0 ? cnt_r : cnt_r - `CNT_W'(1);
    case (state_r)
      H_IDLE: begin
        if (abortReq) begin
          state_nxt = H_SYNC_LOW;
          cnt_nxt   = `CNT_W'(`SYNC_MIN_LOW + `SYNC_MARGIN - 1);
        // R14 only one ack outstanding
        // R09 sent after code, address
        end else if (cmdSent) begin
          state_nxt = H_WAIT_ACK;
        end
      end
      // R05 no upper bound; R13 pin left alone
      H_WAIT_ACK: begin
        if (!pin2_r)
          state_nxt = H_ACK_LOW;
      end
      // R06 free to continue after ack
      H_ACK_LOW: begin
        if (pin2_r)
          state_nxt = H_IDLE;
      end
      // R17 long low, R19 small margin
      H_SYNC_LOW: begin
        if (cnt0) begin
          state_nxt = H_SYNC_SPD;
          cnt_nxt   = `CNT_W'(`SPEEDUP_CYC - 1);
        end
      end
      H_SYNC_SPD: begin
        if (cnt0) begin
          state_nxt = H_SYNC_RESP;
          cnt_nxt   = `CNT_W'(`PIN_SYNC_LAT);
        end
      end
      H_SYNC_RESP: begin
        if (respLow) begin
          cnt_nxt = cnt_r;
          if (pin2_r)
            state_nxt = H_STATUS;
        end else if (settle && !pin2_r) begin
          cnt_nxt = `CNT_W'(`PIN_SYNC_LAT + 1);
        end
      end
      // R20 wait for status cleared
      H_STATUS: begin
        if (statusClear)
          state_nxt = H_IDLE;
      end
      default: state_nxt = H_IDLE;
    endcase
    // R14 abort a pending ack first
    if (abortReq && (state_r == H_WAIT_ACK || state_r == H_STATUS)) begin
      state_nxt = H_SYNC_LOW;
      cnt_nxt   = `CNT_W'(`SYNC_MIN_LOW + `SYNC_MARGIN - 1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= H_IDLE;
      cnt_r   <= `CNT_W'(0);
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinOe_r     <= 1'b0;
      pinOut_r    <= 1'b1;
      ackSeen     <= 1'b0;
      ackWaiting  <= 1'b0;
      syncDone    <= 1'b0;
      statusCheck <= 1'b0;
    end else begin
      pinOe_r     <= state_nxt == H_SYNC_LOW || state_nxt == H_SYNC_SPD;
      pinOut_r    <= state_nxt == H_SYNC_SPD;
      ackSeen     <= state_r == H_ACK_LOW && state_nxt == H_IDLE;
      ackWaiting  <= state_nxt == H_WAIT_ACK || state_nxt == H_ACK_LOW;
      syncDone    <= state_r == H_SYNC_RESP && state_nxt == H_STATUS;
      statusCheck <= state_nxt == H_STATUS;
    end
  end

  assign link.hostOut = pinOut_r;
  assign link.hostOe  = pinOe_r;
endmodule // debug_ack_host

// File: design/debug_ack_params.svh
`ifndef DEBUG_ACK_PARAMS_SVH
`define DEBUG_ACK_PARAMS_SVH
// all counts in debug clock cycles (one mclk each)
`define ACK_LOW_CYC    16
`define ACK_MIN_DLY    32
`define SPEEDUP_CYC    1
`define SYNC_MIN_LOW   128
`define SYNC_MARGIN    4
`define SYNC_RESP_DLY  16
`define SYNC_RESP_LOW  128
`define PIN_SYNC_LAT   3
`define STAT_IDLE      3'h0
`define STAT_PEND      3'h1
`define STAT_FAIL      3'h4
`define CNT_W          8
`endif

// File: design/debug_ack_pkg.sv
package debug_ack_pkg;
  typedef logic [2:0] command_status_field_type;
  typedef enum logic [2:0] {
    T_IDLE, T_ACK_LOW, T_ACK_SPD, T_SYNC_WAIT, T_SYNC_DLY, T_SYNC_LOW,
    T_SYNC_SPD
  } tgt_state_type;
  typedef enum logic [2:0] {
    H_IDLE, H_WAIT_ACK, H_ACK_LOW, H_SYNC_LOW, H_SYNC_SPD, H_SYNC_RESP,
    H_STATUS
  } host_state_type;
endpackage

// File: design/debug_ack_target.sv
`timescale 1ns/1ns
`include "debug_ack_params.svh"
// Notes on behaviour
// R01: async debug clock needs completion handshake
// R02: ack is 16 low cycles, then speedup
// R03: ack starts no sooner than 32 cycles
// R04: command end is 16th cycle, last bit
// R05: host tolerates any ack delay
// R06: after ack host reads or sends next
// R07: stop before execution discards, no ack
// R08: after stop, status stays 001
// R09: read sends code then address
// R10: decoded command passed to cpu
// R11: track stolen access until complete
// R12: ack when tracked access completes
// R13: host keeps off pin during ack
// R14: no nested acks; abort first
// R15: stop at arrival discards the command
// R16: pending ack never times out
// R17: host aborts with 128-cycle low, speedup
// R18: long low runs sync, cancels ack
// R19: host sync only slightly over 128
// R20: host waits status cleared after abort
// R21: handshake off after reset, enable/disable
// R22: ack only cpu commands without status; the enable command also acks itself (enAck)
// R23: status 001 pending, 000 idle, 1xx fail
// R24: cpu completion synchronised before ack
module debug_ack_target
  import debug_ack_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  debug_pin_link.target link,
  input  wire logic cmdValid,
  input  wire logic cmdNeedsCpu,
  input  wire logic cmdHasStatus,
  input  wire logic cmdAckEnable,
  input  wire logic cmdAckDisable,
  input  wire logic cpuDoneTgl,
  input  wire logic cpuFailed,
  input  wire logic stopMode,
  output logic      cpuReqTgl,
  output command_status_field_type cmdStatus,
  output logic      ackEnabled,
  output logic      ackBusy,
  output logic      syncSeen
);
  tgt_state_type   state_r;
  tgt_state_type   state_nxt;
  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] cnt_nxt;
  logic [`CNT_W-1:0] lowCnt_r;
  logic [`CNT_W-1:0] sinceCnt_r;
  logic            pin1_r;
  logic            pin2_r;
  logic            done1_r;
  logic            done2_r;
  logic            done3_r;
  logic            fail1_r;
  logic            fail2_r;
  logic            stop1_r;
  logic            stop2_r;
  logic            stop3_r;
  logic            busy_r;
  logic            wantAck_r;
  logic            ackDue_r;
  logic            pinOut_r;
  logic            pinOe_r;

  wire doneEvt  = done2_r ^ done3_r;
  wire stopRise = stop2_r && !stop3_r;
  wire minMet   = sinceCnt_r >= `CNT_W'(`ACK_MIN_DLY);
  wire syncHit  = lowCnt_r >= `CNT_W'(`SYNC_MIN_LOW);
  wire cnt0     = cnt_r == `CNT_W'(0);
  // R15 stop at arrival discards
  // R14 busy refuses nesting
  wire cpuCmd   = cmdValid && cmdNeedsCpu && !stop2_r && !busy_r;
  // R22 only cpu commands without status
  wire cmdAcks  = ackEnabled && !cmdHasStatus;
  // R22 enable command acks itself
  wire enAck    = cmdValid && cmdAckEnable;
  wire inSync   = state_r == T_SYNC_WAIT || state_r == T_SYNC_DLY ||
                  state_r == T_SYNC_LOW || state_r == T_SYNC_SPD;

  // R01 cpu clock may be async
  // R24 two-flop crossing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {done1_r, done2_r, done3_r} <= 3'h0;
      {fail1_r, fail2_r} <= 2'h0;
      {stop1_r, stop2_r, stop3_r} <= 3'h0;
      {pin1_r, pin2_r} <= 2'h3;
    end else begin
      {done1_r, done2_r, done3_r} <= {cpuDoneTgl, done1_r, done2_r};
      {fail1_r, fail2_r} <= {cpuFailed, fail1_r};
      {stop1_r, stop2_r, stop3_r} <= {stopMode, stop1_r, stop2_r};
      {pin1_r, pin2_r} <= {link.pinLevel, pin1_r};
    end
  end

  // R04 delay counted from command end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      sinceCnt_r <= `CNT_W'(`ACK_MIN_DLY);
    else if (cmdValid)
      sinceCnt_r <= `CNT_W'(0);
    else if (!minMet)
      sinceCnt_r <= sinceCnt_r + `CNT_W'(1);
  end

  // own drive is masked; saturates at the threshold
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      lowCnt_r <= `CNT_W'(0);
    else if (pin2_r || pinOe_r)
      lowCnt_r <= `CNT_W'(0);
    else if (!syncHit)
      lowCnt_r <= lowCnt_r + `CNT_W'(1);
  end

  // R21 handshake off after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      ackEnabled <= 1'b0;
    else if (cmdValid && cmdAckEnable)
      ackEnabled <= 1'b1;
    else if (cmdValid && cmdAckDisable)
      ackEnabled <= 1'b0;
  end

  // R10 pass command to cpu
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      cpuReqTgl <= 1'b0;
    else if (cpuCmd)
      cpuReqTgl <= !cpuReqTgl;
  end

  // R11 track access until done
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      busy_r <= 1'b0;
    else if (cpuCmd)
      busy_r <= 1'b1;
    else if (doneEvt || stopRise)
      busy_r <= 1'b0;
  end

  // R23 status encoding
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      cmdStatus <= `STAT_IDLE;
    else if (cpuCmd)
      cmdStatus <= `STAT_PEND;
    else if (doneEvt && busy_r)
      cmdStatus <= fail2_r ? `STAT_FAIL : `STAT_IDLE;
    // R08 stop keeps 001
    else if (stopRise && busy_r)
      cmdStatus <= `STAT_PEND;
  end

  // R07 stop cancels ack; R18 sync cancels ack
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      wantAck_r <= 1'b0;
    else if (cpuCmd)
      wantAck_r <= cmdAcks;
    else if (stopRise || syncHit || doneEvt)
      wantAck_r <= 1'b0;
  end

  // R12 ack on completion; R16 no timeout
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      ackDue_r <= 1'b0;
    else if (syncHit || state_r == T_ACK_LOW)
      ackDue_r <= 1'b0;
    else if (enAck || (doneEvt && busy_r && wantAck_r && !fail2_r))
      ackDue_r <= 1'b1;
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt0 ? cnt_r : cnt_r - `CNT_W'(1);
    case (state_r)
      T_IDLE: begin
        // R03 not before minimum delay
        if (ackDue_r && minMet) begin
          state_nxt = T_ACK_LOW;
          cnt_nxt   = `CNT_W'(`ACK_LOW_CYC - 1);
        end
      end
      // R02 sixteen low cycles
      T_ACK_LOW: begin
        if (cnt0) begin
          state_nxt = T_ACK_SPD;
          cnt_nxt   = `CNT_W'(`SPEEDUP_CYC - 1);
        end
      end
      T_ACK_SPD: begin
        if (cnt0)
          state_nxt = T_IDLE;
      end
      // R18 wait for host release
      T_SYNC_WAIT: begin
        if (pin2_r) begin
          state_nxt = T_SYNC_DLY;
          cnt_nxt   = `CNT_W'(`SYNC_RESP_DLY - 1);
        end
      end
      T_SYNC_DLY: begin
        if (cnt0) begin
          state_nxt = T_SYNC_LOW;
          cnt_nxt   = `CNT_W'(`SYNC_RESP_LOW - 1);
        end
      end
      T_SYNC_LOW: begin
        if (cnt0) begin
          state_nxt = T_SYNC_SPD;
          cnt_nxt   = `CNT_W'(`SPEEDUP_CYC - 1);
        end
      end
      T_SYNC_SPD: begin
        if (cnt0)
          state_nxt = T_IDLE;
      end
      default: state_nxt = T_IDLE;
    endcase
    // R18 long low aborts any state outside the sync sequence
    if (syncHit && !inSync)
      state_nxt = T_SYNC_WAIT;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= T_IDLE;
      cnt_r   <= `CNT_W'(0);
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // registered pin drive; speedup drives high actively
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinOe_r  <= 1'b0;
      pinOut_r <= 1'b1;
      ackBusy  <= 1'b0;
      syncSeen <= 1'b0;
    end else begin
      pinOe_r  <= state_nxt == T_ACK_LOW || state_nxt == T_ACK_SPD ||
                  state_nxt == T_SYNC_LOW || state_nxt == T_SYNC_SPD;
      pinOut_r <= state_nxt == T_ACK_SPD || state_nxt == T_SYNC_SPD;
      ackBusy  <= ackDue_r || wantAck_r || state_nxt == T_ACK_LOW ||
                  state_nxt == T_ACK_SPD;
      syncSeen <= state_r == T_SYNC_SPD && state_nxt == T_IDLE;
    end
  end

  assign link.tgtOut = pinOut_r;
  assign link.tgtOe  = pinOe_r;
endmodule // debug_ack_target

// File: verif/debug_ack_handshake_bench.sv
`timescale 1ns/1ns
module debug_ack_handshake_bench;
  import debug_ack_pkg::*;
  logic      mclk, reset_n, cmdValid, cmdNeedsCpu, cmdHasStatus;
  logic      cmdAckEnable, cmdAckDisable, cpuDoneTgl, cpuFailed;
  logic      stopMode, cpuReqTgl, ackEnabled, ackBusy, syncSeen;
  logic      cmdSent, abortReq, statusClear, ackSeen, ackWaiting;
  logic      syncDone, statusCheck, oeQ;
  command_status_field_type cmdStatus;
  int        failCount, checked, cyc, t0, gap, acks, syncs, expAcks;
  debug_pin_link link ();
  debug_ack_target u_debug_ack_target (.mclk(mclk), .reset_n(reset_n),
    .link(link), .cmdValid(cmdValid), .cmdNeedsCpu(cmdNeedsCpu),
    .cmdHasStatus(cmdHasStatus), .cmdAckEnable(cmdAckEnable),
    .cmdAckDisable(cmdAckDisable), .cpuDoneTgl(cpuDoneTgl),
    .cpuFailed(cpuFailed), .stopMode(stopMode), .cpuReqTgl(cpuReqTgl),
    .cmdStatus(cmdStatus), .ackEnabled(ackEnabled), .ackBusy(ackBusy),
    .syncSeen(syncSeen));
  debug_ack_host u_debug_ack_host (.mclk(mclk), .reset_n(reset_n),
    .link(link), .cmdSent(cmdSent), .abortReq(abortReq),
    .statusClear(statusClear), .ackSeen(ackSeen),
    .ackWaiting(ackWaiting), .syncDone(syncDone),
    .statusCheck(statusCheck));
  debug_ack_sva u_debug_ack_sva (.mclk(mclk), .reset_n(reset_n),
    .tgtOut(link.tgtOut), .tgtOe(link.tgtOe), .hostOut(link.hostOut),
    .hostOe(link.hostOe), .pinLevel(link.pinLevel));
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checked %0d failCount %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_stat(input command_status_field_type e);
    chk("cmdStatus", {5'h00, e}, {5'h00, cmdStatus});
  endtask
  task automatic cmd(input logic cpu, st, en, dis, snt);
    @(negedge mclk);
    cmdValid = 1;
    cmdNeedsCpu = cpu;
    cmdHasStatus = st;
    cmdAckEnable = en;
    cmdAckDisable = dis;
    cmdSent = snt;
    @(negedge mclk);
    cmdValid = 0;
    cmdSent = 0;
  endtask
  task automatic done(input int d);
    repeat (d) @(negedge mclk);
    cpuDoneTgl = !cpuDoneTgl;
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1;
    @(negedge mclk);
    s = 0;
  endtask
  // bounded wait: a lost ack shows up as a stuck busy, not a hang
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((ackBusy !== 0 || ackWaiting !== 0) && n < 400);
    repeat (8) @(negedge mclk);
  endtask
  // bounded wait for the end of a sync response
  task automatic wait_sync();
    int n;
    n = 0;
    while (syncDone !== 1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    chk("syncDone", 1, syncDone);
  endtask
  // monitor: ack start gap, pulse counts and the run ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cmdValid) t0 = cyc;
    if (link.tgtOe && !oeQ && ackBusy) gap = cyc - t0;
    oeQ = link.tgtOe;
    if (ackSeen) acks++;
    if (syncSeen) syncs++;
    if (cyc > 20000) begin
      failCount++;
      final_report();
    end
  end
  initial begin
    int i;
    logic tgl;
    {reset_n, cmdValid, cmdNeedsCpu, cmdHasStatus, cmdAckEnable} = 0;
    {cmdAckDisable, cpuDoneTgl, cpuFailed, stopMode, cmdSent} = 0;
    {abortReq, statusClear} = 0;
    repeat (10) @(negedge mclk);
    reset_n = 1;
    void'($urandom(23032));
    chk_stat(3'h0);
    chk("ackEnabled", 0, ackEnabled);
    cmd(0, 0, 1, 0, 1);
    expAcks++;
    settle();
    chk("ackEnabled", 1, ackEnabled);
    chk("acks", expAcks, acks);
    $display("test enable done");
    for (i = 0; i < 4; i++) begin
      gap = 0;
      tgl = cpuReqTgl;
      cmd(1, 0, 0, 0, 1);
      chk("cpuReqTgl", !tgl, cpuReqTgl);
      chk_stat(3'h1);
      done(i == 0 ? 2 : 1 + $urandom % 80);
      expAcks++;
      settle();
      chk_stat(3'h0);
      chk("acks", expAcks, acks);
      chk("gapOk", 1, gap > 33);
    end
    $display("test ack done");
    cmd(1, 1, 0, 0, 0);
    done(5);
    settle();
    chk_stat(3'h0);
    chk("acks", expAcks, acks);
    cpuFailed = 1;
    cmd(1, 0, 0, 0, 0);
    done(5);
    settle();
    chk_stat(3'h4);
    chk("acks", expAcks, acks);
    cpuFailed = 0;
    $display("test status done");
    stopMode = 1;
    tgl = cpuReqTgl;
    repeat (4) @(negedge mclk);
    cmd(1, 0, 0, 0, 0);
    repeat (5) @(negedge mclk);
    chk_stat(3'h4);
    chk("cpuReqTgl", tgl, cpuReqTgl);
    stopMode = 0;
    repeat (4) @(negedge mclk);
    cmd(1, 0, 0, 0, 1);
    repeat (3) @(negedge mclk);
    stopMode = 1;
    settle();
    chk_stat(3'h1);
    chk("acks", expAcks, acks);
    chk("ackWaiting", 1, ackWaiting);
    $display("test stop done");
    stopMode = 0;
    pulse(abortReq);
    wait_sync();
    chk("syncs", 1, syncs);
    chk_stat(3'h1);
    chk("statusCheck", 1, statusCheck);
    chk("ackWaiting", 0, ackWaiting);
    // abort a command that the cpu is still executing
    cmd(1, 0, 0, 0, 0);
    pulse(abortReq);
    wait_sync();
    chk("syncs", 2, syncs);
    chk("ackBusy", 0, ackBusy);
    chk_stat(3'h1);
    done(3);
    settle();
    chk_stat(3'h0);
    chk("acks", expAcks, acks);
    pulse(statusClear);
    @(negedge mclk);
    chk("statusCheck", 0, statusCheck);
    $display("test abort done");
    cmd(0, 0, 0, 1, 0);
    cmd(1, 0, 0, 0, 0);
    done(4);
    settle();
    chk("ackEnabled", 0, ackEnabled);
    chk("acks", expAcks, acks);
    chk_stat(3'h0);
    $display("test disable done");
    final_report();
  end
endmodule // debug_ack_handshake_bench

// File: verif/debug_ack_sva.sv
`timescale 1ns/1ns
module debug_ack_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tgtOut,
  input wire logic tgtOe,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic pinLevel
);
  logic [7:0] tLow_r;
  logic [7:0] hLow_r;
  // low-phase lengths, so pulse widths are checked exactly
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tLow_r <= 8'h00;
      hLow_r <= 8'h00;
    end else begin
      tLow_r <= (tgtOe && !tgtOut) ? tLow_r + 8'h01 : 8'h00;
      hLow_r <= (hostOe && !hostOut) ? hLow_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_ackLen;
    $rose(tgtOut) && tgtOe |-> tLow_r == 8'h10 || tLow_r == 8'h80;
  endproperty
  a_ackLen: assert property (p_ackLen)
    else $error("target low phase has wrong length");
  property p_ackLow;
    $rose(tgtOe) |-> (tgtOe && !tgtOut) [*8];
  endproperty
  a_ackLow: assert property (p_ackLow)
    else $error("target low phase broken early");
  property p_tgtSpd;
    tgtOe && tgtOut |=> !tgtOe;
  endproperty
  a_tgtSpd: assert property (p_tgtSpd)
    else $error("target speedup longer than one cycle");
  property p_spdCause;
    tgtOe && tgtOut |-> $past(tgtOe) && !$past(tgtOut);
  endproperty
  a_spdCause: assert property (p_spdCause)
    else $error("target drove high without low phase");
  property p_tgtRel;
    $fell(tgtOe) |-> $past(tgtOut);
  endproperty
  a_tgtRel: assert property (p_tgtRel)
    else $error("target released without speedup");
  property p_noClash;
    !(tgtOe && hostOe);
  endproperty
  a_noClash: assert property (p_noClash)
    else $error("both ends drive the pin");
  property p_syncLen;
    $rose(hostOut) && hostOe |-> hLow_r == 8'h84;
  endproperty
  a_syncLen: assert property (p_syncLen)
    else $error("host sync low length wrong");
  property p_hostSpd;
    hostOe && hostOut |=> !hostOe;
  endproperty
  a_hostSpd: assert property (p_hostSpd)
    else $error("host speedup longer than one cycle");
  property p_syncResp;
    $fell(hostOe) |-> ##[1:40] (tgtOe && !tgtOut && !pinLevel);
  endproperty
  a_syncResp: assert property (p_syncResp)
    else $error("no sync response after host abort");
endmodule // debug_ack_sva
